// ===== pkg/fsp_pkg.sv
package fsp_pkg;
	// Action select codes on a crystal-pin pulse
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;
	// Command bytes
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
	localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
	localparam logic [7:0] CMD_READ_SIG = 8'h08;
	localparam logic [7:0] CMD_READ_FUSE = 8'h04;
	// Fuse defaults, 0 means programmed
	localparam logic [7:0] EXT_FUSE_DEFAULT = 8'hFF;
	localparam logic [7:0] HIGH_FUSE_DEFAULT = 8'h99;
	localparam logic [7:0] LOW_FUSE_DEFAULT = 8'h62;
	localparam logic [7:0] LOCK_DEFAULT = 8'hFF;
	localparam logic [7:0] EXT_UNUSED_MASK = 8'hF0;
	// Field positions
	localparam int HF_SERIAL_PROG_BIT = 5;
	localparam int HF_EEPROM_PRESERVE_BIT = 3;
	localparam int LOCK_FIRST_BIT = 0;
	// Signature space
	localparam logic [1:0] SIG_ADDR_LAST = 2'h2;
	localparam logic [7:0] SIG_BYTE0 = 8'h5A; // Arbitrary value
	localparam logic [7:0] SIG_BYTE1 = 8'h3C; // Arbitrary value
	localparam logic [7:0] SIG_BYTE2 = 8'h42; // Arbitrary value
	localparam logic [7:0] OSC_CAL_DEFAULT = 8'h80;
	// Busy times
	localparam int CLK_PERIOD_NS = 8;
	localparam int FUSE_WRITE_NS = 4000;
	localparam int ERASE_NS = 9000;
	localparam int FUSE_WRITE_CYC = FUSE_WRITE_NS / CLK_PERIOD_NS;
	localparam int ERASE_CYC = ERASE_NS / CLK_PERIOD_NS;
	localparam logic [10:0] BUSY_CNT_ZERO = 11'h000;
endpackage

// ===== design/fsp_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of pin inputs
module fsp_sync #(
	parameter int W = 1
) (
	input wire logic mclk, // Clock
	input wire logic rst, // Synchronous reset
	input wire logic [W-1:0] pin_in, // Asynchronous pins
	output logic [W-1:0] sync_out // Synchronised copy
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge mclk) begin
		if (rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= pin_in;
			sync_out <= meta_reg;
		end
	end
endmodule // fsp_sync

// ===== design/fsp_top.sv
`timescale 1ns/1ps
module fsp_top
	import fsp_pkg::*;
(
	input wire logic mclk, // Clock, 125 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic prog_mode, // Parallel programming mode active (pin domain)
	input wire logic serial_mode, // Serial programming mode active (pin domain)
	input wire logic crystal_strobe_pin, // Load strobe, positive pulse
	input wire logic action_select_b0, // Action select bit 0
	input wire logic action_select_b1, // Action select bit 1
	input wire logic byte_select_one, // Byte select 1
	input wire logic byte_select_two, // Byte select 2
	input wire logic page_load_strobe, // Page load strobe, positive pulse
	input wire logic wr_n, // Write strobe, active low
	input wire logic oe_n, // Output enable, active low
	input wire logic [7:0] data_in, // Data bus input
	output logic [7:0] data_out, // Data bus output
	output logic data_oe, // Data bus output enable
	output logic ready_busy_out, // High ready, low busy
	output logic [7:0] ext_fuse_active, // Latched extended fuses
	output logic [7:0] high_fuse_active, // Latched high fuses
	output logic [7:0] low_fuse_active, // Latched low fuses
	output logic eeprom_preserve_active, // Immediate eeprom preserve, active low
	output logic [7:0] osc_calibration_reg, // Oscillator calibration
	output logic erase_pulse, // Chip erase start, one cycle
	output logic erase_eeprom, // Erase also clears eeprom
	output logic page_latch_pulse, // Page buffer latch, one cycle
	output logic [15:0] page_word // Word latched to page buffer
);
	localparam logic [10:0] FUSE_WRITE_LEN = 11'(FUSE_WRITE_CYC);
	localparam logic [10:0] ERASE_LEN = 11'(ERASE_CYC);

	typedef struct packed {
		logic [7:0] ext_fuse;
		logic [7:0] high_fuse;
		logic [7:0] low_fuse;
		logic [7:0] lock;
		logic [7:0] ext_act;
		logic [7:0] high_act;
		logic [7:0] low_act;
		logic [7:0] osc_cal;
		logic [7:0] cmd;
		logic [15:0] addr;
		logic [15:0] data;
		logic [7:0] dout;
		logic [10:0] busy_cnt;
		logic xtal_d;
		logic wr_d;
		logic oe_d;
		logic page_d;
		logic prog_d;
		logic started;
		logic erase;
		logic erase_ee;
		logic page_pulse;
		logic [15:0] page_word;
	} fsp_state_t;

	fsp_state_t st_reg;
	fsp_state_t st_next;
	logic [9:0] sync_in;
	logic [7:0] data_sync;
	logic xtal_s, act0_s, act1_s, bs1_s, bs2_s, page_s, wr_s, oe_s, prog_s, ser_s;
	logic [1:0] act_code;
	logic fuse_locked;

	// Pins from the programmer pass two flops before use
	fsp_sync #(.W(18)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.pin_in({prog_mode, serial_mode, crystal_strobe_pin, action_select_b0,
			action_select_b1, byte_select_one, byte_select_two, page_load_strobe,
			wr_n, oe_n, data_in}),
		.sync_out({sync_in, data_sync})
	);
	assign {prog_s, ser_s, xtal_s, act0_s, act1_s, bs1_s, bs2_s, page_s, wr_s, oe_s} = sync_in;
	assign act_code = {act1_s, act0_s};
	assign fuse_locked = ~st_reg.lock[LOCK_FIRST_BIT];

	// Next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.xtal_d = xtal_s;
		st_next.wr_d = wr_s;
		st_next.oe_d = oe_s;
		st_next.page_d = page_s;
		st_next.prog_d = prog_s;
		st_next.erase = 1'b0;
		st_next.page_pulse = 1'b0;
		// Power-up capture in either mode, then on programming entry and on programming exit
		if (!st_reg.started) begin
			st_next.started = 1'b1;
			st_next.ext_act = st_reg.ext_fuse;
			st_next.high_act = st_reg.high_fuse;
			st_next.low_act = st_reg.low_fuse;
		end else if (prog_s && !st_reg.prog_d) begin
			st_next.ext_act = st_reg.ext_fuse;
			st_next.high_act = st_reg.high_fuse;
			st_next.low_act = st_reg.low_fuse;
		end else if (!prog_s && st_reg.prog_d) begin
			st_next.ext_act = st_reg.ext_fuse;
			st_next.high_act = st_reg.high_fuse;
			st_next.low_act = st_reg.low_fuse;
		end
		// Busy countdown
		if (st_reg.busy_cnt != BUSY_CNT_ZERO) begin
			st_next.busy_cnt = st_reg.busy_cnt - 11'h001;
		end
		// Load actions on rising crystal strobe
		if (prog_s && xtal_s && !st_reg.xtal_d) begin
			unique case (act_code)
				ACT_ADDR: begin
					if (bs1_s) st_next.addr[15:8] = data_sync;
					else st_next.addr[7:0] = data_sync;
				end
				ACT_DATA: begin
					if (bs1_s) st_next.data[15:8] = data_sync;
					else st_next.data[7:0] = data_sync;
				end
				ACT_CMD: st_next.cmd = data_sync;
				ACT_IDLE: st_next.cmd = st_reg.cmd;
			endcase
		end
		// Page load latches the assembled word
		if (prog_s && page_s && !st_reg.page_d) begin
			st_next.page_pulse = 1'b1;
			st_next.page_word = st_reg.data;
		end
		// Write strobe falling edge executes the loaded command
		if (prog_s && !wr_s && st_reg.wr_d && st_reg.busy_cnt == BUSY_CNT_ZERO) begin
			if (st_reg.cmd == CMD_CHIP_ERASE) begin
				st_next.erase = 1'b1;
				st_next.erase_ee = st_reg.high_fuse[HF_EEPROM_PRESERVE_BIT];
				st_next.lock = LOCK_DEFAULT;
				st_next.busy_cnt = ERASE_LEN;
			end else if (st_reg.cmd == CMD_WRITE_FUSE) begin
				st_next.busy_cnt = FUSE_WRITE_LEN;
				if (!fuse_locked) begin
					if (bs2_s) begin
						st_next.ext_fuse = data_sync | EXT_UNUSED_MASK;
					end else if (bs1_s) begin
						st_next.high_fuse = data_sync;
						if (ser_s) begin
							st_next.high_fuse[HF_SERIAL_PROG_BIT] =
								st_reg.high_fuse[HF_SERIAL_PROG_BIT];
						end
					end else begin
						st_next.low_fuse = data_sync;
					end
				end
			end else if (st_reg.cmd == CMD_WRITE_LOCK) begin
				st_next.lock = st_reg.lock & data_sync;
				st_next.busy_cnt = FUSE_WRITE_LEN;
			end
		end
		// Output enable falling edge samples read data
		if (prog_s && !oe_s && st_reg.oe_d) begin
			if (st_reg.cmd == CMD_READ_FUSE) begin
				if (bs2_s && bs1_s) st_next.dout = st_reg.high_fuse;
				else if (bs2_s) st_next.dout = st_reg.ext_fuse;
				else if (bs1_s) st_next.dout = st_reg.lock;
				else st_next.dout = st_reg.low_fuse;
			end else if (st_reg.cmd == CMD_READ_SIG) begin
				if (bs1_s) st_next.dout = st_reg.osc_cal;
				else if (st_reg.addr[1:0] == 2'h0) st_next.dout = SIG_BYTE0;
				else if (st_reg.addr[1:0] == 2'h1) st_next.dout = SIG_BYTE1;
				else if (st_reg.addr[1:0] == SIG_ADDR_LAST) st_next.dout = SIG_BYTE2;
				else st_next.dout = 8'hFF;
			end else begin
				st_next.dout = 8'hFF;
			end
		end
	end

	// State register; calibration copied during reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.ext_fuse <= EXT_FUSE_DEFAULT;
			st_reg.high_fuse <= HIGH_FUSE_DEFAULT;
			st_reg.low_fuse <= LOW_FUSE_DEFAULT;
			st_reg.lock <= LOCK_DEFAULT;
			st_reg.ext_act <= EXT_FUSE_DEFAULT;
			st_reg.high_act <= HIGH_FUSE_DEFAULT;
			st_reg.low_act <= LOW_FUSE_DEFAULT;
			st_reg.osc_cal <= OSC_CAL_DEFAULT;
			st_reg.dout <= 8'hFF;
			st_reg.xtal_d <= 1'b0;
			st_reg.wr_d <= 1'b1;
			st_reg.oe_d <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs
	assign data_out = st_reg.dout;
	assign data_oe = prog_s & ~oe_s;
	assign ready_busy_out = (st_reg.busy_cnt == BUSY_CNT_ZERO);
	assign ext_fuse_active = st_reg.ext_act;
	assign high_fuse_active = st_reg.high_act;
	assign low_fuse_active = st_reg.low_act;
	assign eeprom_preserve_active = st_reg.high_fuse[HF_EEPROM_PRESERVE_BIT];
	assign osc_calibration_reg = st_reg.osc_cal;
	assign erase_pulse = st_reg.erase;
	assign erase_eeprom = st_reg.erase_ee;
	assign page_latch_pulse = st_reg.page_pulse;
	assign page_word = st_reg.page_word;

	// Fuses do not move across a chip erase
	property erase_keeps_fuse;
		@(posedge mclk) disable iff (rst)
		st_reg.erase |-> $stable(st_reg.high_fuse) && $stable(st_reg.low_fuse);
	endproperty
	fuse_erase_a: assert property (erase_keeps_fuse) else $error("fuse changed by erase");

	sequence wr_fall_s;
		prog_s && !wr_s && st_reg.wr_d && ready_busy_out;
	endsequence
	// Locked device keeps fuses
	fuse_lock_a: assert property (@(posedge mclk) disable iff (rst)
		(wr_fall_s and fuse_locked) |=> $stable(st_reg.low_fuse) && $stable(st_reg.high_fuse))
		else $error("fuse written while locked");
	// Busy follows an accepted write of fuses
	busy_write_a: assert property (@(posedge mclk) disable iff (rst)
		(wr_fall_s and st_reg.cmd == CMD_WRITE_FUSE) |=> !ready_busy_out [*8])
		else $error("ready during fuse write");
	// Bus driven only under output enable
	bus_drive_a: assert property (@(posedge mclk) disable iff (rst)
		data_oe |-> !$past(oe_n, 2)) else $error("bus driven without enable");
	// Extended unused bits read 1
	ext_unused_a: assert property (@(posedge mclk) disable iff (rst)
		(st_reg.ext_fuse & EXT_UNUSED_MASK) == EXT_UNUSED_MASK) else $error("unused ext bit low");
	// Active fuses hold still during programming
	fuse_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(st_reg.started && prog_s && st_reg.prog_d) |=> $stable(st_reg.low_act))
		else $error("active fuses moved in programming");
	// Preserve output follows a written high fuse at once
	preserve_now_a: assert property (@(posedge mclk) disable iff (rst)
		(wr_fall_s and (st_reg.cmd == CMD_WRITE_FUSE && bs1_s && !bs2_s && !fuse_locked))
		|=> eeprom_preserve_active == $past(data_sync[HF_EEPROM_PRESERVE_BIT]))
		else $error("preserve not immediate");
	// Command load on crystal strobe
	cmd_load_a: assert property (@(posedge mclk) disable iff (rst)
		(prog_s && xtal_s && !st_reg.xtal_d && act_code == ACT_CMD) |=> st_reg.cmd == $past(data_sync))
		else $error("command not loaded");
	// Erase keeps eeprom when preserve programmed
	erase_ee_a: assert property (@(posedge mclk) disable iff (rst)
		st_reg.erase |-> st_reg.erase_ee == $past(st_reg.high_fuse[HF_EEPROM_PRESERVE_BIT]))
		else $error("eeprom erase mismatch");

	sequence oe_fall_s;
		prog_s && !oe_s && st_reg.oe_d;
	endsequence
	// Serial mode never moves the serial programming fuse
	serial_keep_a: assert property (@(posedge mclk) disable iff (rst)
		(wr_fall_s and (st_reg.cmd == CMD_WRITE_FUSE && bs1_s && !bs2_s && ser_s))
		|=> $stable(st_reg.high_fuse[HF_SERIAL_PROG_BIT]))
		else $error("serial fuse changed in serial mode");
	// Erase starts and raises busy
	erase_busy_a: assert property (@(posedge mclk) disable iff (rst)
		(wr_fall_s and st_reg.cmd == CMD_CHIP_ERASE) |=> st_reg.erase && !ready_busy_out)
		else $error("erase did not start");
	// Active fuses taken from storage on programming exit
	fuse_exit_a: assert property (@(posedge mclk) disable iff (rst)
		(st_reg.started && !prog_s && st_reg.prog_d)
		|=> low_fuse_active == $past(st_reg.low_fuse))
		else $error("fuses not taken on exit");
	// Active fuses taken from storage after power-up
	power_cap_a: assert property (@(posedge mclk) disable iff (rst)
		!st_reg.started |=> high_fuse_active == $past(st_reg.high_fuse))
		else $error("fuses not taken at power-up");
	// Low fuse read returns the stored byte
	fuse_read_a: assert property (@(posedge mclk) disable iff (rst)
		(oe_fall_s and (st_reg.cmd == CMD_READ_FUSE && !bs1_s && !bs2_s))
		|=> data_out == $past(st_reg.low_fuse))
		else $error("low fuse read wrong");
	// Last signature byte read at its address
	sig_read_a: assert property (@(posedge mclk) disable iff (rst)
		(oe_fall_s and (st_reg.cmd == CMD_READ_SIG && !bs1_s
		&& st_reg.addr[1:0] == SIG_ADDR_LAST)) |=> data_out == SIG_BYTE2)
		else $error("signature byte wrong");
	// Page latch pulse lasts one cycle
	page_pulse_a: assert property (@(posedge mclk) disable iff (rst)
		page_latch_pulse |=> !page_latch_pulse)
		else $error("page pulse too long");
endmodule // fsp_top

// ===== dv/fsp_prog_model.sv
`timescale 1ns/1ps
// Parallel programmer model: drives pins at the falling edge, holds each strobe 32 cycles, the write strobe 33
module fsp_prog_model
	import fsp_pkg::*;
(
	input wire logic mclk, // Clock
	input wire logic [7:0] data_out, // Device data
	input wire logic data_oe, // Device drives bus
	input wire logic ready_busy_out, // Device ready
	output logic xtal, // Load strobe
	output logic [1:0] act, // Action select
	output logic bs1, // Byte select 1
	output logic bs2, // Byte select 2
	output logic page_ld, // Page load strobe
	output logic wr_n, // Write strobe
	output logic oe_n, // Output enable
	output logic [7:0] data_in // Resolved bus
);
	localparam int P = 32;
	logic [7:0] drv = 8'h00;
	// Bus level: device, else programmer, else a value that is never stale
	assign data_in = data_oe ? data_out : (oe_n ? drv : ~data_out);
	initial begin
		{xtal, page_ld, bs1, bs2} = 4'h0;
		{wr_n, oe_n} = 2'h3;
		act = ACT_IDLE;
	end
	// Set up action, byte selects and data, then pulse the load strobe
	task automatic load(input logic [1:0] a, input logic [7:0] d, input logic b1, b2);
		@(negedge mclk);
		act = a;
		drv = d;
		bs1 = b1;
		bs2 = b2;
		repeat (4) @(negedge mclk);
		xtal = 1'b1;
		repeat (P) @(negedge mclk);
		xtal = 1'b0;
		repeat (P) @(negedge mclk);
		act = ACT_IDLE;
	endtask
	// Page load pulse
	task automatic page();
		page_ld = 1'b1;
		repeat (P) @(negedge mclk);
		page_ld = 1'b0;
		repeat (P) @(negedge mclk);
	endtask
	// Write pulse after ready; counts the cycles that ready stays low
	task automatic write(output int busy);
		int i;
		busy = 0;
		for (i = 0; i < 3000 && ready_busy_out !== 1'b1; i++) @(negedge mclk);
		wr_n = 1'b0;
		for (i = 0; i < 3000; i++) begin
			@(negedge mclk);
			if (i == P) wr_n = 1'b1;
			if (ready_busy_out !== 1'b1) busy++;
			else if (busy > 0 && i > P) break;
		end
	endtask
	// Output enable pulse; data taken before the bus is released
	task automatic read(input logic b1, b2, output logic [7:0] d, output logic oe);
		bs1 = b1;
		bs2 = b2;
		repeat (4) @(negedge mclk);
		oe_n = 1'b0;
		repeat (P) @(negedge mclk);
		d = data_out;
		oe = data_oe;
		oe_n = 1'b1;
		repeat (P) @(negedge mclk);
	endtask
endmodule // fsp_prog_model

// ===== dv/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the fuse, signature and programming pins
module testbench;
	import fsp_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, prog_mode = 1'b0, serial_mode = 1'b0;
	logic xtal, bs1, bs2, page_ld, wr_n, oe_n, rdy, data_oe, eep_a, ers, ers_ee, pgp;
	logic [1:0] act;
	logic [7:0] data_in, data_out, ext_a, high_a, low_a, osc, lo, ex, hi;
	logic [15:0] page_word, pg_seen, pg_exp;
	logic [7:0] sig [3] = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2};
	int n_mismatch = 0, n_checks = 0, n_erase = 0, n_page = 0, seed, k, e0;
	logic ee_seen, rd_oe;
	logic [7:0] rd_d;
	always #4 mclk = ~mclk;
	fsp_top fsp_top_inst (.mclk(mclk), .rst(rst), .prog_mode(prog_mode),
		.serial_mode(serial_mode), .crystal_strobe_pin(xtal), .action_select_b0(act[0]),
		.action_select_b1(act[1]), .byte_select_one(bs1), .byte_select_two(bs2),
		.page_load_strobe(page_ld), .wr_n(wr_n), .oe_n(oe_n), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .ready_busy_out(rdy), .ext_fuse_active(ext_a),
		.high_fuse_active(high_a), .low_fuse_active(low_a), .eeprom_preserve_active(eep_a),
		.osc_calibration_reg(osc), .erase_pulse(ers), .erase_eeprom(ers_ee),
		.page_latch_pulse(pgp), .page_word(page_word));
	fsp_prog_model prg (.mclk(mclk), .data_out(data_out), .data_oe(data_oe),
		.ready_busy_out(rdy), .xtal(xtal), .act(act), .bs1(bs1), .bs2(bs2),
		.page_ld(page_ld), .wr_n(wr_n), .oe_n(oe_n), .data_in(data_in));
	// Catch the one-cycle pulses
	always @(posedge mclk) begin
		if (ers === 1'b1) begin
			n_erase <= n_erase + 1;
			ee_seen <= ers_ee;
		end
		if (pgp === 1'b1) begin
			n_page <= n_page + 1;
			pg_seen <= page_word;
		end
	end
	function automatic logic [7:0] f_ext(input logic [7:0] v);
		return v | 8'hF0;
	endfunction
	function automatic logic [7:0] f_ser(input logic [7:0] old, input logic [7:0] v);
		return (v & 8'hDF) | (old & 8'h20);
	endfunction
	task automatic check(input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic go(input int n);
		int b;
		prg.write(b);
		check(16'(b >= n - 1 && b <= n + 1), 16'h0001);
	endtask
	task automatic chk_act(input logic [7:0] e, h, l);
		check(ext_a, e);
		check(high_a, h);
		check(low_a, l);
	endtask
	// Read the four fuse and lock bytes
	task automatic rd_fuses(input logic [7:0] e, h, l, lk);
		logic [7:0] d;
		logic oe;
		prg.load(ACT_CMD, CMD_READ_FUSE, 1'b0, 1'b0);
		prg.read(1'b0, 1'b0, d, oe);
		check(d, l);
		check(oe, 1'b1);
		prg.read(1'b1, 1'b0, d, oe);
		check(d, lk);
		prg.read(1'b0, 1'b1, d, oe);
		check(d, e);
		prg.read(1'b1, 1'b1, d, oe);
		check(d, h);
		check(data_oe, 1'b0);
	endtask
	task automatic wfuse(input logic b1, b2, input logic [7:0] v);
		prg.load(ACT_CMD, CMD_WRITE_FUSE, 1'b0, 1'b0);
		prg.load(ACT_DATA, v, b1, b2);
		go(FUSE_WRITE_CYC);
	endtask
	// Signature bytes at 0..2, calibration in the high byte of address 0
	task automatic rd_sig();
		logic [7:0] d;
		logic oe;
		prg.load(ACT_CMD, CMD_READ_SIG, 1'b0, 1'b0);
		for (int a = 2; a >= 0; a--) begin
			prg.load(ACT_ADDR, 8'(a), 1'b0, 1'b0);
			prg.read(1'b0, 1'b0, d, oe);
			check(d, sig[a]);
		end
		prg.read(1'b1, 1'b0, d, oe);
		check(d, OSC_CAL_DEFAULT);
	endtask
	initial begin
		seed = 89519;
		repeat (6) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		chk_act(8'hFF, 8'h99, 8'h62);
		check(osc, OSC_CAL_DEFAULT);
		check(rdy, 1'b1);
		prog_mode = 1'b1;
		repeat (8) @(negedge mclk);
		rd_fuses(8'hFF, 8'h99, 8'h62, 8'hFF);
		prg.load(ACT_IDLE, CMD_CHIP_ERASE, 1'b0, 1'b0);
		prg.read(1'b0, 1'b0, rd_d, rd_oe);
		check(rd_d, 8'h62);
		check(16'(n_erase), 16'h0000);
		$display("test defaults done");
		// Corner bytes first, then random; active copies stay frozen
		for (k = 0; k < 3; k++) begin
			lo = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
			ex = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
			hi = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
			wfuse(1'b0, 1'b0, lo);
			wfuse(1'b0, 1'b1, ex);
			wfuse(1'b1, 1'b0, hi);
			chk_act(8'hFF, 8'h99, 8'h62);
			check(eep_a, hi[3]);
			rd_fuses(f_ext(ex), hi, lo, 8'hFF);
		end
		prog_mode = 1'b0;
		repeat (8) @(negedge mclk);
		chk_act(f_ext(ex), hi, lo);
		prog_mode = 1'b1;
		repeat (8) @(negedge mclk);
		$display("test fuse write done");
		serial_mode = 1'b1;
		wfuse(1'b1, 1'b0, ~hi);
		hi = f_ser(hi, ~hi);
		serial_mode = 1'b0;
		rd_fuses(f_ext(ex), hi, lo, 8'hFF);
		$display("test serial guard done");
		for (k = 0; k < 2; k++) begin
			hi[3] = k[0];
			wfuse(1'b1, 1'b0, hi);
			e0 = n_erase;
			prg.load(ACT_CMD, CMD_CHIP_ERASE, 1'b0, 1'b0);
			go(ERASE_CYC);
			check(16'(n_erase), 16'(e0 + 1));
			check(ee_seen, hi[3]);
			rd_fuses(f_ext(ex), hi, lo, 8'hFF);
		end
		$display("test erase done");
		for (k = 0; k < 2; k++) begin
			e0 = n_page;
			pg_exp = {8'($random(seed)), 8'($random(seed))};
			prg.load(ACT_DATA, pg_exp[7:0], 1'b0, 1'b0);
			prg.load(ACT_DATA, pg_exp[15:8], 1'b1, 1'b0);
			prg.page();
			check(16'(n_page), 16'(e0 + 1));
			check(pg_seen, pg_exp);
		end
		$display("test page load done");
		rd_sig();
		prg.load(ACT_CMD, CMD_WRITE_LOCK, 1'b0, 1'b0);
		prg.load(ACT_DATA, 8'hFE, 1'b0, 1'b0);
		go(FUSE_WRITE_CYC);
		wfuse(1'b0, 1'b0, ~lo);
		rd_fuses(f_ext(ex), hi, lo, 8'hFE);
		rd_sig();
		$display("test lock done");
		summarize();
	end
	// Watchdog well past the expected run length
	initial begin
		#(CLK_PERIOD_NS * 90000);
		n_mismatch++;
		summarize();
	end
endmodule // testbench
